/* alt_pkg.sv */
package alt_pkg;
  // Block clock
  localparam int unsigned CLK_HZ = 125_000_000;
  // Timeout figures in seconds
  localparam int unsigned RESPONSE_LIMIT_S = 3;
  localparam int unsigned INIT_PROCESS_LIMIT_S = 5;
  localparam int unsigned INIT_WAIT_LIMIT_S = 6;
  localparam int unsigned CONFIRM_PROCESS_LIMIT_S = 3;
  localparam int unsigned DISPOSAL_MIN_WAIT_S = 6;
  localparam int unsigned CONFIRM_ISSUE_LIMIT_S = 3;
  localparam int unsigned CONFIRM_WAIT_LIMIT_S = 5;
  // Cycle counts derived from the clock rate
  localparam longint unsigned RESPONSE_LIMIT_CYC = 64'(RESPONSE_LIMIT_S) * CLK_HZ;
  localparam longint unsigned INIT_PROCESS_LIMIT_CYC = 64'(INIT_PROCESS_LIMIT_S) * CLK_HZ;
  localparam longint unsigned INIT_WAIT_LIMIT_CYC = 64'(INIT_WAIT_LIMIT_S) * CLK_HZ;
  localparam longint unsigned CONFIRM_PROCESS_LIMIT_CYC = 64'(CONFIRM_PROCESS_LIMIT_S) * CLK_HZ;
  localparam longint unsigned DISPOSAL_MIN_WAIT_CYC = 64'(DISPOSAL_MIN_WAIT_S) * CLK_HZ;
  localparam longint unsigned CONFIRM_ISSUE_LIMIT_CYC = 64'(CONFIRM_ISSUE_LIMIT_S) * CLK_HZ;
  localparam longint unsigned CONFIRM_WAIT_LIMIT_CYC = 64'(CONFIRM_WAIT_LIMIT_S) * CLK_HZ;
  localparam int unsigned TIMER_W = 32;
  // Serial rate codes
  localparam int unsigned RATE_W = 3;
  localparam logic [2:0] RATE_2400 = 3'h0;
  localparam logic [2:0] RATE_9600 = 3'h1;
  localparam logic [2:0] RATE_4800 = 3'h2;
  localparam logic [2:0] RATE_19200 = 3'h3;
  localparam logic [2:0] RATE_38400 = 3'h4;
  localparam logic [2:0] RATE_57600 = 3'h5;
  localparam logic [2:0] RATE_115200 = 3'h6;
  // Frame kinds on the link
  localparam int unsigned KIND_W = 2;
  localparam logic [1:0] KIND_REQUEST = 2'h0;
  localparam logic [1:0] KIND_RESPONSE = 2'h1;
  localparam logic [1:0] KIND_ERROR = 2'h2;
  localparam logic [1:0] KIND_CONFIRM = 2'h3;
  localparam int unsigned DATA_W = 8;

  typedef enum logic [1:0] {
    ALT_IDLE = 2'b00,
    ALT_WAIT = 2'b01,
    ALT_FAIL = 2'b10
  } alt_req_state_t;

  typedef enum logic [2:0] {
    ALT_STOP = 3'b000,
    ALT_INIT = 3'b001,
    ALT_CONFIRM = 3'b010,
    ALT_RUN = 3'b011,
    ALT_INIT_FAIL = 3'b100
  } alt_adapter_state_t;
endpackage

/* alt_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface alt_link_if;
  import alt_pkg::*;
  // Reset line, appliance to adapter
  logic applResetN;
  // Adapter to appliance frame strobe
  logic a2eValid;
  logic [1:0] a2eKind;
  logic [7:0] a2eData;
  // Appliance to adapter frame strobe
  logic e2aValid;
  logic [1:0] e2aKind;
  logic [7:0] e2aData;
  // Agreed bit rate, chosen by the appliance
  logic [2:0] linkRate;

  modport adapter (input applResetN, output a2eValid, output a2eKind, output a2eData,
    input e2aValid, input e2aKind, input e2aData, input linkRate);
  modport appliance (output applResetN, input a2eValid, input a2eKind, input a2eData,
    output e2aValid, output e2aKind, output e2aData, output linkRate);
endinterface
`default_nettype wire

/* alt_req_tracker.sv */
`timescale 1ns/1ps
`default_nettype none
// One outstanding request at a time, with response timeout and retry
module alt_req_tracker
  import alt_pkg::*;
#(
  parameter logic [TIMER_W-1:0] LIMIT = TIMER_W'(RESPONSE_LIMIT_CYC)
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Local request
  input wire logic reqSent,
  input wire logic respSeen,
  input wire logic errSeen,
  // Status
  output logic busy,
  output logic retry
);
  alt_req_state_t state, next_state;
  logic [TIMER_W-1:0] timer, next_timer;
  logic next_retry;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_retry = 1'b0;
    unique case (state)
      ALT_IDLE: begin
        // Timer starts at the end of the request frame
        if (reqSent) begin
          next_state = ALT_WAIT;
          next_timer = '0;
        end
      end
      ALT_WAIT: begin
        next_timer = timer + 1'b1;
        if (respSeen) begin
          next_state = ALT_IDLE;
        end else if (errSeen || timer >= LIMIT - 1'b1) begin
          // Error frame treated like timeout
          next_state = ALT_FAIL;
        end
      end
      ALT_FAIL: begin
        next_retry = 1'b1;
        next_state = ALT_IDLE;
      end
      default: next_state = ALT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ALT_IDLE;
      timer <= '0;
      retry <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      retry <= next_retry;
    end
  end

  // No second request while one is pending
  assign busy = (state != ALT_IDLE);
endmodule
`default_nettype wire

/* alt_adapter_end.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Answer any request within three seconds
// - Finish initialization within five seconds
// - Declare init failed after six seconds
// - Appliance confirms interface data within three seconds
// - Appliance waits six seconds for disposal
// - Appliance issues confirmation within three seconds
// - Adapter confirmation wait limit five seconds
// - Confirm wait exceeds both appliance limits
// - Low reset stops adapter, rise restarts
// - Both parties implement the reset function
// - Adapter supports 2400 and 9600 bps
// - Appliance supports 2400 or 9600 bps
// - Optional extra rates only beyond both base
// - One request outstanding; drop overlapping requests
// - Drop bad frame, send error; resend (only once running; a bad confirm or response frame is still taken)
module alt_adapter_end
  import alt_pkg::*;
#(
  parameter logic [TIMER_W-1:0] RESP_LIMIT = TIMER_W'(RESPONSE_LIMIT_CYC),
  parameter logic [TIMER_W-1:0] INIT_LIMIT = TIMER_W'(INIT_PROCESS_LIMIT_CYC),
  parameter logic [TIMER_W-1:0] CONFIRM_LIMIT = TIMER_W'(CONFIRM_WAIT_LIMIT_CYC),
  parameter bit EXTRA_RATES = 1'b1
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Link
  alt_link_if.adapter link,
  // User request path
  input wire logic userReqValid,
  input wire logic [7:0] userReqData,
  output logic userReqReady,
  // User answer to appliance requests
  input wire logic userRespValid,
  input wire logic [7:0] userRespData,
  // Received frames and reception errors
  input wire logic rxError,
  output logic rxValid,
  output logic [7:0] rxData,
  // Status
  output logic stopped,
  output logic running,
  output logic initFail,
  output logic respLate,
  output logic retryReq,
  output logic rateOk
);
  // Inconsistent limits make every initialization fail on its first confirm-phase cycle, so the fault cannot go unseen
  localparam bit LIMITS_ORDERED = (CONFIRM_WAIT_LIMIT_S > CONFIRM_PROCESS_LIMIT_S) &&
    (CONFIRM_WAIT_LIMIT_S > CONFIRM_ISSUE_LIMIT_S);

  alt_adapter_state_t state, next_state;
  logic [TIMER_W-1:0] phaseTimer, next_phaseTimer;
  logic [TIMER_W-1:0] answerTimer, next_answerTimer;
  logic owed, next_owed;
  logic resetSeen, next_resetSeen;
  logic next_rxValid, next_respLate, next_initFail;
  logic [7:0] next_rxData;
  logic a2eValid, next_a2eValid;
  logic [1:0] a2eKind, next_a2eKind;
  logic [7:0] a2eData, next_a2eData;
  logic trkBusy, trkRetry;
  logic sendReq, respIn, errIn, reqIn, confirmIn;

  assign respIn = link.e2aValid && link.e2aKind == KIND_RESPONSE;
  assign errIn = link.e2aValid && link.e2aKind == KIND_ERROR;
  assign reqIn = link.e2aValid && link.e2aKind == KIND_REQUEST;
  assign confirmIn = link.e2aValid && link.e2aKind == KIND_CONFIRM;
  assign sendReq = userReqValid && userReqReady;
  // A bad incoming frame takes the strobe for the error frame, so no request then
  assign userReqReady = running && !trkBusy && !a2eValid && !owed && !(rxError && link.e2aValid);

  alt_req_tracker #(.LIMIT(RESP_LIMIT)) u_trk (
    .clk(clk),
    .srst(srst || !running),
    .reqSent(sendReq),
    .respSeen(respIn),
    .errSeen(errIn),
    .busy(trkBusy),
    .retry(trkRetry)
  );

  always_comb begin
    next_state = state;
    next_phaseTimer = phaseTimer + 1'b1;
    next_answerTimer = answerTimer;
    next_owed = owed;
    next_resetSeen = link.applResetN;
    next_rxValid = 1'b0;
    next_rxData = rxData;
    next_respLate = 1'b0;
    next_initFail = initFail;
    next_a2eValid = 1'b0;
    next_a2eKind = a2eKind;
    next_a2eData = a2eData;
    if (!link.applResetN) begin
      next_state = ALT_STOP;
      next_phaseTimer = '0;
      next_owed = 1'b0;
      next_initFail = 1'b0;
    end else begin
      unique case (state)
        ALT_STOP: begin
          // Rising edge of the reset line starts initialization
          if (!resetSeen) begin
            next_state = ALT_INIT;
            next_phaseTimer = '0;
          end
        end
        ALT_INIT: begin
          if (phaseTimer >= INIT_LIMIT - 1'b1) begin
            next_state = ALT_CONFIRM;
            next_phaseTimer = '0;
            next_a2eValid = 1'b1;
            next_a2eKind = KIND_CONFIRM;
            next_a2eData = 8'h00;
          end
        end
        ALT_CONFIRM: begin
          if (confirmIn && LIMITS_ORDERED) begin
            next_state = ALT_RUN;
          end else if (!LIMITS_ORDERED || phaseTimer >= CONFIRM_LIMIT - 1'b1) begin
            next_state = ALT_INIT_FAIL;
            next_initFail = 1'b1;
          end
        end
        ALT_RUN: begin
          if (rxError && link.e2aValid) begin
            // Faulty frame is dropped and answered with an error frame
            next_a2eValid = 1'b1;
            next_a2eKind = KIND_ERROR;
            next_a2eData = 8'h00;
          end else if (reqIn && !owed) begin
            next_owed = 1'b1;
            next_answerTimer = '0;
            next_rxValid = 1'b1;
            next_rxData = link.e2aData;
          end else if (link.e2aValid && !reqIn) begin
            next_rxValid = 1'b1;
            next_rxData = link.e2aData;
          end
          // A request overlapping a pending answer is discarded
          if (owed) begin
            next_answerTimer = answerTimer + 1'b1;
            if (answerTimer == RESP_LIMIT - 1'b1) begin
              next_respLate = 1'b1;
            end
            if (userRespValid && !(rxError && link.e2aValid)) begin
              next_owed = 1'b0;
              next_a2eValid = 1'b1;
              next_a2eKind = KIND_RESPONSE;
              next_a2eData = userRespData;
            end
          end else if (sendReq) begin
            next_a2eValid = 1'b1;
            next_a2eKind = KIND_REQUEST;
            next_a2eData = userReqData;
          end
        end
        ALT_INIT_FAIL: begin
          next_initFail = 1'b1;
        end
        default: next_state = ALT_STOP;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ALT_STOP;
      phaseTimer <= '0;
      answerTimer <= '0;
      owed <= 1'b0;
      resetSeen <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      respLate <= 1'b0;
      initFail <= 1'b0;
      a2eValid <= 1'b0;
      a2eKind <= KIND_REQUEST;
      a2eData <= 8'h00;
    end else begin
      state <= next_state;
      phaseTimer <= next_phaseTimer;
      answerTimer <= next_answerTimer;
      owed <= next_owed;
      resetSeen <= next_resetSeen;
      rxValid <= next_rxValid;
      rxData <= next_rxData;
      respLate <= next_respLate;
      initFail <= next_initFail;
      a2eValid <= next_a2eValid;
      a2eKind <= next_a2eKind;
      a2eData <= next_a2eData;
    end
  end

  assign link.a2eValid = a2eValid;
  assign link.a2eKind = a2eKind;
  assign link.a2eData = a2eData;
  assign stopped = (state == ALT_STOP);
  assign running = (state == ALT_RUN);
  assign retryReq = trkRetry;
  // Both base rates always; extra rates only when enabled
  always_comb begin
    unique case (link.linkRate)
      RATE_2400, RATE_9600: rateOk = 1'b1;
      RATE_4800, RATE_19200, RATE_38400, RATE_57600, RATE_115200: rateOk = EXTRA_RATES;
      default: rateOk = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* alt_appliance_end.sv */
`timescale 1ns/1ps
`default_nettype none
// Appliance controller end of the adapter link
module alt_appliance_end
  import alt_pkg::*;
#(
  parameter logic [TIMER_W-1:0] RESP_LIMIT = TIMER_W'(RESPONSE_LIMIT_CYC),
  parameter logic [TIMER_W-1:0] INIT_WAIT = TIMER_W'(INIT_WAIT_LIMIT_CYC),
  parameter logic [TIMER_W-1:0] CONFIRM_LIMIT = TIMER_W'(CONFIRM_ISSUE_LIMIT_CYC),
  parameter logic [TIMER_W-1:0] DISPOSAL_WAIT = TIMER_W'(DISPOSAL_MIN_WAIT_CYC),
  parameter logic [2:0] RATE = RATE_9600
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Link
  alt_link_if.appliance link,
  // Control
  input wire logic holdAdapter,
  input wire logic userReqValid,
  input wire logic [7:0] userReqData,
  output logic userReqReady,
  input wire logic rxError,
  // Status
  output logic rxValid,
  output logic [7:0] rxData,
  output logic initFail,
  output logic disposalDone,
  output logic retryReq
);
  logic resetN, next_resetN;
  logic [TIMER_W-1:0] timer, next_timer;
  logic waitInit, next_waitInit;
  logic confirmOwed, next_confirmOwed;
  logic next_initFail, next_disposalDone, next_rxValid;
  logic [7:0] next_rxData;
  logic e2aValid, next_e2aValid;
  logic [1:0] e2aKind, next_e2aKind;
  logic [7:0] e2aData, next_e2aData;
  logic trkBusy;
  logic sendReq, confirmIn;

  assign confirmIn = link.a2eValid && link.a2eKind == KIND_CONFIRM;
  assign sendReq = userReqValid && userReqReady;
  // Incoming frames and the owed confirmation take the strobe first
  assign userReqReady = resetN && !waitInit && !confirmOwed && !trkBusy && !e2aValid && !link.a2eValid;

  alt_req_tracker #(.LIMIT(RESP_LIMIT)) u_trk (
    .clk(clk),
    .srst(srst || !resetN),
    .reqSent(sendReq),
    .respSeen(link.a2eValid && link.a2eKind == KIND_RESPONSE),
    .errSeen(link.a2eValid && link.a2eKind == KIND_ERROR),
    .busy(trkBusy),
    .retry(retryReq)
  );

  always_comb begin
    next_resetN = !holdAdapter;
    next_timer = timer + 1'b1;
    next_waitInit = waitInit;
    next_confirmOwed = confirmOwed;
    next_initFail = initFail;
    next_disposalDone = disposalDone;
    next_rxValid = 1'b0;
    next_rxData = rxData;
    next_e2aValid = 1'b0;
    next_e2aKind = e2aKind;
    next_e2aData = e2aData;
    if (!resetN) begin
      next_timer = '0;
      next_waitInit = 1'b1;
      next_confirmOwed = 1'b0;
      next_initFail = 1'b0;
      next_disposalDone = 1'b0;
    end else if (waitInit) begin
      if (confirmIn) begin
        next_waitInit = 1'b0;
        next_confirmOwed = 1'b1;
        next_timer = '0;
      end else if (timer >= INIT_WAIT - 1'b1) begin
        next_initFail = 1'b1;
        next_waitInit = 1'b0;
      end
    end else if (confirmOwed) begin
      // Confirmation is sent at once, well inside its limits
      next_confirmOwed = 1'b0;
      next_e2aValid = 1'b1;
      next_e2aKind = KIND_CONFIRM;
      next_e2aData = 8'h00;
    end else begin
      if (timer >= DISPOSAL_WAIT - 1'b1) begin
        next_disposalDone = 1'b1;
      end
      if (link.a2eValid && rxError) begin
        next_e2aValid = 1'b1;
        next_e2aKind = KIND_ERROR;
        next_e2aData = 8'h00;
      end else if (link.a2eValid && link.a2eKind == KIND_REQUEST) begin
        // Requests are answered in the next cycle
        next_e2aValid = 1'b1;
        next_e2aKind = KIND_RESPONSE;
        next_e2aData = link.a2eData;
        next_rxValid = 1'b1;
        next_rxData = link.a2eData;
      end else if (link.a2eValid) begin
        next_rxValid = 1'b1;
        next_rxData = link.a2eData;
      end else if (sendReq) begin
        next_e2aValid = 1'b1;
        next_e2aKind = KIND_REQUEST;
        next_e2aData = userReqData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      resetN <= 1'b0;
      timer <= '0;
      waitInit <= 1'b1;
      confirmOwed <= 1'b0;
      initFail <= 1'b0;
      disposalDone <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      e2aValid <= 1'b0;
      e2aKind <= KIND_REQUEST;
      e2aData <= 8'h00;
    end else begin
      resetN <= next_resetN;
      timer <= next_timer;
      waitInit <= next_waitInit;
      confirmOwed <= next_confirmOwed;
      initFail <= next_initFail;
      disposalDone <= next_disposalDone;
      rxValid <= next_rxValid;
      rxData <= next_rxData;
      e2aValid <= next_e2aValid;
      e2aKind <= next_e2aKind;
      e2aData <= next_e2aData;
    end
  end

  assign link.applResetN = resetN;
  assign link.e2aValid = e2aValid;
  assign link.e2aKind = e2aKind;
  assign link.e2aData = e2aData;
  assign link.linkRate = RATE;
endmodule
`default_nettype wire

/* alt_link_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module alt_link_asserts
  import alt_pkg::*;
#(
  parameter int INIT_MAX = 58
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Link
  input wire logic applResetN,
  input wire logic a2eValid,
  input wire logic [1:0] a2eKind,
  input wire logic [7:0] a2eData,
  input wire logic e2aValid,
  input wire logic [1:0] e2aKind,
  input wire logic [7:0] e2aData,
  input wire logic [2:0] linkRate
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic aReq;
  logic eReq;
  assign aReq = a2eValid && a2eKind == KIND_REQUEST;
  assign eReq = e2aValid && e2aKind == KIND_REQUEST;

  a_reset_low: assert property ($fell(srst) |-> !applResetN)
    else $error("reset line high right after block reset");
  a_stop_quiet: assert property (!applResetN && $past(applResetN) == 1'b0 |-> !a2eValid)
    else $error("adapter sent a frame while held stopped");
  a_wake_init: assert property ($rose(applResetN) |-> ##[1:INIT_MAX] (a2eValid && a2eKind == KIND_CONFIRM))
    else $error("adapter did not finish initialization in time");
  // Receipt is registered first, the reply strobe follows on the next cycle
  a_confirm_reply: assert property (a2eValid && a2eKind == KIND_CONFIRM |-> ##2 (e2aValid && e2aKind == KIND_CONFIRM))
    else $error("appliance confirmation reply missing");
  a_req_answer: assert property (aReq |=> e2aValid && (e2aKind == KIND_RESPONSE || e2aKind == KIND_ERROR))
    else $error("appliance did not answer the request");
  a_one_request: assert property (eReq |=> (!eReq) [*2])
    else $error("appliance sent a second request too soon");
  a_no_req_owed: assert property (eReq |=> (!aReq) [*2])
    else $error("adapter requested while owing an answer");
  a_rate_base: assert property (linkRate == RATE_2400 || linkRate == RATE_9600)
    else $error("appliance rate is not a base rate");

  c_wake: cover property ($rose(applResetN));
  c_err_appl: cover property (e2aValid && e2aKind == KIND_ERROR);
  c_err_adapt: cover property (a2eValid && a2eKind == KIND_ERROR);
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import alt_pkg::*;
  // Short limits keep the run brief; appliance confirm 40 stays under adapter wait 100
  localparam logic [31:0] RL = 32'h0000_003C;
  localparam logic [31:0] IL = 32'h0000_0032;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic holdAdapter = 1'b1;
  logic aReqValid = 1'b0, aRespValid = 1'b0, aRxErr = 1'b0, eReqValid = 1'b0, eRxErr = 1'b0;
  logic [7:0] aReqData = 8'h00, aRespData = 8'h00, eReqData = 8'h00;
  logic aReqReady, aRxValid, stopped, running, aInitFail, respLate, aRetry, rateOk;
  logic eReqReady, eRxValid, eInitFail, disposalDone, eRetry;
  logic [7:0] aRxData, eRxData;
  int failures = 0, n_compared = 0, cyc = 0, n = 0;

  always #4 clk = ~clk;

  alt_link_if alt_link_if_i ();
  alt_adapter_end #(.RESP_LIMIT(RL), .INIT_LIMIT(IL), .CONFIRM_LIMIT(32'h0000_0064)) alt_adapter_end_i (
    .clk(clk), .srst(srst), .link(alt_link_if_i.adapter),
    .userReqValid(aReqValid), .userReqData(aReqData), .userReqReady(aReqReady),
    .userRespValid(aRespValid), .userRespData(aRespData), .rxError(aRxErr), .rxValid(aRxValid),
    .rxData(aRxData), .stopped(stopped), .running(running), .initFail(aInitFail),
    .respLate(respLate), .retryReq(aRetry), .rateOk(rateOk));
  alt_appliance_end #(.RESP_LIMIT(RL), .INIT_WAIT(32'h0000_0078), .CONFIRM_LIMIT(32'h0000_0028),
    .DISPOSAL_WAIT(32'h0000_0078)) alt_appliance_end_i (
    .clk(clk), .srst(srst), .link(alt_link_if_i.appliance), .holdAdapter(holdAdapter),
    .userReqValid(eReqValid), .userReqData(eReqData), .userReqReady(eReqReady), .rxError(eRxErr),
    .rxValid(eRxValid), .rxData(eRxData), .initFail(eInitFail), .disposalDone(disposalDone),
    .retryReq(eRetry));
  alt_link_asserts #(.INIT_MAX(int'(IL) + 8)) alt_link_asserts_i (
    .clk(clk), .srst(srst), .applResetN(alt_link_if_i.applResetN),
    .a2eValid(alt_link_if_i.a2eValid), .a2eKind(alt_link_if_i.a2eKind), .a2eData(alt_link_if_i.a2eData),
    .e2aValid(alt_link_if_i.e2aValid), .e2aKind(alt_link_if_i.e2aKind), .e2aData(alt_link_if_i.e2aData),
    .linkRate(alt_link_if_i.linkRate));

  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pulses last one cycle, so poll every cycle just after the edge
  task automatic waitHi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic t_init();
    tick(3);
    check(stopped, 1'b1);
    check(alt_link_if_i.applResetN, 1'b0);
    holdAdapter = 1'b0;
    waitHi(running, int'(IL) + 20);
    check(running, 1'b1);
    check(n <= int'(IL) + 8, 1'b1);
    check(aInitFail, 1'b0);
    check(eInitFail, 1'b0);
    check(disposalDone, 1'b0);
    check(rateOk, 1'b1);
    check(alt_link_if_i.linkRate, RATE_9600);
    $display("t_init done");
  endtask

  task automatic t_areq();
    aReqData = 8'hA5;
    aReqValid = 1'b1;
    tick();
    aReqValid = 1'b0;
    check(aReqReady, 1'b0);
    waitHi(eRxValid, 5);
    check(eRxData, 8'hA5);
    waitHi(aReqReady, 5);
    check(aReqReady, 1'b1);
    $display("t_areq done");
  endtask

  task automatic t_ereq();
    eReqData = 8'h3C;
    eReqValid = 1'b1;
    tick();
    eReqValid = 1'b0;
    check(eReqReady, 1'b0);
    waitHi(aRxValid, 5);
    check(aRxData, 8'h3C);
    check(aReqReady, 1'b0);
    aRespData = 8'hC3;
    aRespValid = 1'b1;
    tick();
    aRespValid = 1'b0;
    waitHi(eReqReady, 5);
    check(eReqReady, 1'b1);
    $display("t_ereq done");
  endtask

  // A frame is marked bad in the cycle its strobe stands on the link
  task automatic t_err();
    aReqData = 8'h5A;
    aReqValid = 1'b1;
    tick();
    aReqValid = 1'b0;
    eRxErr = 1'b1;
    tick();
    eRxErr = 1'b0;
    waitHi(aRetry, 6);
    check(aRetry, 1'b1);
    waitHi(aReqReady, 5);
    eReqData = 8'h11;
    eReqValid = 1'b1;
    tick();
    eReqValid = 1'b0;
    aRxErr = 1'b1;
    tick();
    aRxErr = 1'b0;
    waitHi(eRetry, 6);
    check(eRetry, 1'b1);
    $display("t_err done");
  endtask

  // The unanswered request makes the adapter late in the same cycle the appliance retries
  task automatic t_late();
    tick(4);
    eReqData = 8'h77;
    eReqValid = 1'b1;
    tick();
    eReqValid = 1'b0;
    waitHi(eRetry, int'(RL) + 20);
    check(eRetry, 1'b1);
    check(n + 4 >= int'(RL), 1'b1);
    check(respLate, 1'b1);
    $display("t_late done");
  endtask

  task automatic t_hold();
    waitHi(disposalDone, int'(RL) + 80);
    check(disposalDone, 1'b1);
    holdAdapter = 1'b1;
    tick(3);
    check(stopped, 1'b1);
    check(disposalDone, 1'b0);
    tick(20);
    check(running, 1'b0);
    holdAdapter = 1'b0;
    waitHi(running, int'(IL) + 20);
    check(running, 1'b1);
    $display("t_hold done");
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    tick(2);
    srst = 1'b0;
    t_init();
    t_areq();
    t_ereq();
    t_err();
    t_late();
    t_hold();
    t_areq();
    conclude();
  end
endmodule
`default_nettype wire
